// *** rtl/compare_bank.sv ***
// compare value bytes, comparator enables and match detection of all modules
`timescale 1ns/10ps
`include "counter_array_consts.svh"
module compare_bank #(
  parameter int NUM_MODULES = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // front end side
  compare_bus_if.bank cmp
);
  import counter_array_pkg::*;

  count_t value_reg [NUM_MODULES];
  logic [NUM_MODULES-1:0] enable_reg;
  logic [NUM_MODULES-1:0] match_reg;

  // compare value bytes, each byte written on its own strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        value_reg[i] <= `CA_RESET_COUNT;
      end
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (cmp.wrLow[i]) begin
          value_reg[i][7:0] <= cmp.wrData;
        end
        if (cmp.wrHigh[i]) begin
          value_reg[i][15:8] <= cmp.wrData;
        end
      end
    end
  end

  // comparator enables: low byte write clears, high byte write sets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (cmp.wrLow[i]) begin
          enable_reg[i] <= 1'b0;
        end else if (cmp.wrHigh[i]) begin
          enable_reg[i] <= 1'b1;
        end else if (cmp.wrMode[i] && !cmp.enableLock[i]) begin
          enable_reg[i] <= cmp.wrData[`CA_MODE_ENABLE_BIT];
        end
      end
    end
  end

  // match flag, registered, held while an enabled module equals the running count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        match_reg[i] <= enable_reg[i] && (cmp.count == value_reg[i]);
      end
    end
  end

  // results back to the front end
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      cmp.value[i] = value_reg[i];
    end
    cmp.enable = enable_reg;
    cmp.match = match_reg;
  end
endmodule : compare_bank

// *** rtl/compare_bus_if.sv ***
// write strobes and compare state between the register front end and the compare bank
`timescale 1ns/10ps
interface compare_bus_if #(parameter int NUM_MODULES = 5);
  import counter_array_pkg::*;
  logic [NUM_MODULES-1:0] wrLow;
  logic [NUM_MODULES-1:0] wrHigh;
  logic [NUM_MODULES-1:0] wrMode;
  logic [NUM_MODULES-1:0] enableLock;
  byte_t wrData;
  count_t count;
  count_t value [NUM_MODULES];
  logic [NUM_MODULES-1:0] enable;
  logic [NUM_MODULES-1:0] match;

  modport ctrl (
    output wrLow, wrHigh, wrMode, enableLock, wrData, count,
    input value, enable, match
  );
  modport bank (
    input wrLow, wrHigh, wrMode, enableLock, wrData, count,
    output value, enable, match
  );
endinterface : compare_bus_if

// *** rtl/counter_array_consts.svh ***
// offsets, field positions, reset values and watchdog module of the counter array registers
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

// counter byte addresses
`define CA_ADDR_COUNT_LOW 8'hF9
`define CA_ADDR_COUNT_HIGH 8'hFA

// compare value byte addresses, per module
`define CA_ADDR_CMP0_LOW 8'hFB
`define CA_ADDR_CMP0_HIGH 8'hFC
`define CA_ADDR_CMP1_LOW 8'hE9
`define CA_ADDR_CMP1_HIGH 8'hEA
`define CA_ADDR_CMP2_LOW 8'hEB
`define CA_ADDR_CMP2_HIGH 8'hEC
`define CA_ADDR_CMP3_LOW 8'hED
`define CA_ADDR_CMP3_HIGH 8'hEE
`define CA_ADDR_CMP4_LOW 8'hFD
`define CA_ADDR_CMP4_HIGH 8'hFE

// module mode register addresses, only the comparator enable bit lives here
`define CA_ADDR_MODE0 8'hDA
`define CA_ADDR_MODE1 8'hDB
`define CA_ADDR_MODE2 8'hDC
`define CA_ADDR_MODE3 8'hDD
`define CA_ADDR_MODE4 8'hDE
`define CA_MODE_ENABLE_BIT 6

// module that doubles as the watchdog
`define CA_WATCHDOG_MODULE 3'h4

// reset values
`define CA_RESET_BYTE 8'h00
`define CA_RESET_COUNT 16'h0000

`endif

// *** rtl/counter_array_pkg.sv ***
// types and address decode of the counter array register block
package counter_array_pkg;
  `include "counter_array_consts.svh"

  typedef logic [7:0] byte_t;
  typedef logic [15:0] count_t;
  typedef logic [2:0] module_index_t;

  // what a register address selects
  typedef enum logic [2:0] {
    ACC_NONE = 3'b000,
    ACC_COUNT_LOW = 3'b001,
    ACC_COUNT_HIGH = 3'b010,
    ACC_CMP_LOW = 3'b011,
    ACC_CMP_HIGH = 3'b100,
    ACC_MODE = 3'b101
  } access_e;

  typedef struct packed {
    access_e kind;
    module_index_t index;
  } decode_s;

  // map an address onto its register kind and module index
  function automatic decode_s decodeAddr(input byte_t addr);
    decode_s d;
    d.kind = ACC_NONE;
    d.index = 3'h0;
    case (addr)
      `CA_ADDR_COUNT_LOW: d.kind = ACC_COUNT_LOW;
      `CA_ADDR_COUNT_HIGH: d.kind = ACC_COUNT_HIGH;
      `CA_ADDR_CMP0_LOW: d = '{ACC_CMP_LOW, 3'h0};
      `CA_ADDR_CMP1_LOW: d = '{ACC_CMP_LOW, 3'h1};
      `CA_ADDR_CMP2_LOW: d = '{ACC_CMP_LOW, 3'h2};
      `CA_ADDR_CMP3_LOW: d = '{ACC_CMP_LOW, 3'h3};
      `CA_ADDR_CMP4_LOW: d = '{ACC_CMP_LOW, 3'h4};
      `CA_ADDR_CMP0_HIGH: d = '{ACC_CMP_HIGH, 3'h0};
      `CA_ADDR_CMP1_HIGH: d = '{ACC_CMP_HIGH, 3'h1};
      `CA_ADDR_CMP2_HIGH: d = '{ACC_CMP_HIGH, 3'h2};
      `CA_ADDR_CMP3_HIGH: d = '{ACC_CMP_HIGH, 3'h3};
      `CA_ADDR_CMP4_HIGH: d = '{ACC_CMP_HIGH, 3'h4};
      `CA_ADDR_MODE0: d = '{ACC_MODE, 3'h0};
      `CA_ADDR_MODE1: d = '{ACC_MODE, 3'h1};
      `CA_ADDR_MODE2: d = '{ACC_MODE, 3'h2};
      `CA_ADDR_MODE3: d = '{ACC_MODE, 3'h3};
      `CA_ADDR_MODE4: d = '{ACC_MODE, 3'h4};
      default: d.kind = ACC_NONE;
    endcase
    return d;
  endfunction : decodeAddr
endpackage : counter_array_pkg

// *** rtl/counter_array_regs.sv ***
// register front end of the 16-bit counter array with its five compare modules
`timescale 1ns/10ps
`include "counter_array_consts.svh"
module counter_array_regs #(
  parameter int NUM_MODULES = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // special function register bus
  input wire counter_array_pkg::byte_t sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire counter_array_pkg::byte_t sfrWrData,
  output counter_array_pkg::byte_t sfrRdData,
  output logic sfrRdValid,
  output logic sfrRdHit,
  // control from the mode logic, same clock
  input wire logic watchdogEnable,
  input wire logic countTick,
  // status
  output counter_array_pkg::count_t countValue,
  output logic [NUM_MODULES-1:0] compareEnable,
  output logic [NUM_MODULES-1:0] compareMatch,
  output logic watchdogActive
);
  import counter_array_pkg::*;

  count_t count_reg;
  count_t count_next;
  byte_t snapshot_reg;
  byte_t rdData_reg;
  byte_t rdData_next;
  logic rdHit_next;
  logic rdValid_reg;
  logic rdHit_reg;
  logic watchdog_reg;
  decode_s dec;
  logic wrCountLow;
  logic wrCountHigh;
  logic rdCountLow;

  compare_bus_if #(.NUM_MODULES(NUM_MODULES)) cmpBus ();

  compare_bank #(.NUM_MODULES(NUM_MODULES)) bank (
    .clk(clk),
    .rstn(rstn),
    .cmp(cmpBus.bank)
  );

  // one address serves both read and write in a cycle
  assign dec = decodeAddr(sfrAddr);
  assign wrCountLow = sfrWrEn && (dec.kind == ACC_COUNT_LOW) && !watchdogEnable;
  assign wrCountHigh = sfrWrEn && (dec.kind == ACC_COUNT_HIGH) && !watchdogEnable;
  assign rdCountLow = sfrRdEn && (dec.kind == ACC_COUNT_LOW);

  // per module write strobes toward the compare bank
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      cmpBus.wrLow[i] = sfrWrEn && (dec.kind == ACC_CMP_LOW)
                        && (dec.index == module_index_t'(i));
      cmpBus.wrHigh[i] = sfrWrEn && (dec.kind == ACC_CMP_HIGH)
                         && (dec.index == module_index_t'(i));
      cmpBus.wrMode[i] = sfrWrEn && (dec.kind == ACC_MODE)
                         && (dec.index == module_index_t'(i));
      cmpBus.enableLock[i] = watchdogEnable
                             && (module_index_t'(i) == `CA_WATCHDOG_MODULE);
    end
    cmpBus.wrData = sfrWrData;
    cmpBus.count = count_reg;
  end

  // next count: tick first, an unlocked byte write then replaces its byte
  always_comb begin
    count_next = count_reg + {15'h0000, countTick};
    if (wrCountLow) begin
      count_next[7:0] = sfrWrData;
    end
    if (wrCountHigh) begin
      count_next[15:8] = sfrWrData;
    end
  end

  // running counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= `CA_RESET_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // high byte snapshot taken on a low byte read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snapshot_reg <= `CA_RESET_BYTE;
    end else if (rdCountLow) begin
      snapshot_reg <= count_reg[15:8];
    end
  end

  // read data selection
  always_comb begin
    rdData_next = `CA_RESET_BYTE;
    rdHit_next = 1'b1;
    unique case (dec.kind)
      ACC_COUNT_LOW: rdData_next = count_reg[7:0];
      ACC_COUNT_HIGH: rdData_next = snapshot_reg;
      ACC_CMP_LOW: rdData_next = cmpBus.value[dec.index][7:0];
      ACC_CMP_HIGH: rdData_next = cmpBus.value[dec.index][15:8];
      ACC_MODE: rdHit_next = 1'b0;
      ACC_NONE: rdHit_next = 1'b0;
      default: rdHit_next = 1'b0;
    endcase
  end

  // read answer, held until the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= `CA_RESET_BYTE;
      rdHit_reg <= 1'b0;
    end else if (sfrRdEn) begin
      rdData_reg <= rdData_next;
      rdHit_reg <= rdHit_next;
    end
  end

  // one cycle read valid pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= sfrRdEn;
    end
  end

  // watchdog role of module four, seen from outside
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_reg <= 1'b0;
    end else begin
      watchdog_reg <= watchdogEnable;
    end
  end

  // outputs straight from flip-flops
  assign sfrRdData = rdData_reg;
  assign sfrRdValid = rdValid_reg;
  assign sfrRdHit = rdHit_reg;
  assign countValue = count_reg;
  assign compareEnable = cmpBus.enable;
  assign compareMatch = cmpBus.match;
  assign watchdogActive = watchdog_reg;

  // low byte write with the watchdog on leaves the count untouched
  a_low_write_locked: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_COUNT_LOW && watchdogEnable && !countTick)
    |=> (count_reg == $past(count_reg))
  ) else $error("counter low byte changed under watchdog lock");

  // high byte write with the watchdog on leaves the high byte alone
  a_high_write_locked: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_COUNT_HIGH && watchdogEnable
     && (countTick == 1'b0))
    |=> $stable(count_reg[15:8])
  ) else $error("counter high byte changed under watchdog lock");

  // unlocked low byte write lands in the counter next cycle
  a_low_write_load: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_COUNT_LOW && !watchdogEnable)
    |=> (count_reg[7:0] == $past(sfrWrData))
  ) else $error("counter low byte write not loaded");

  // unlocked high byte write lands in the counter next cycle
  a_high_write_load: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_COUNT_HIGH && !watchdogEnable)
    |=> (count_reg[15:8] == $past(sfrWrData))
  ) else $error("counter high byte write not loaded");

  // low byte read captures the live high byte into the snapshot
  a_snapshot_load: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrRdEn && sfrAddr == `CA_ADDR_COUNT_LOW)
    |=> (snapshot_reg == $past(count_reg[15:8]))
  ) else $error("snapshot not loaded on low byte read");

  // snapshot holds while no low byte read occurs
  a_snapshot_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !(sfrRdEn && sfrAddr == `CA_ADDR_COUNT_LOW) |=> $stable(snapshot_reg)
  ) else $error("snapshot changed without low byte read");

  // high byte read returns the snapshot, then low read then high pairs
  a_high_read_snap: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrRdEn && sfrAddr == `CA_ADDR_COUNT_HIGH)
    |=> (sfrRdValid && sfrRdHit && sfrRdData == $past(snapshot_reg))
  ) else $error("high byte read did not return snapshot");

  // compare low write of module zero clears its enable
  a_low_clears_enable: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_CMP0_LOW) |=> !compareEnable[0]
  ) else $error("compare low write did not clear enable");

  // compare high write of module four sets its enable, even as watchdog
  a_high_sets_enable: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_CMP4_HIGH) |=> compareEnable[4]
  ) else $error("compare high write did not set enable");

  // compare low byte of module one stores the written byte
  a_cmp_low_store: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_CMP1_LOW)
    |=> (cmpBus.value[1][7:0] == $past(sfrWrData))
  ) else $error("compare low byte not stored");

  // compare high byte of module three stores the written byte
  a_cmp_high_store: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_CMP3_HIGH)
    |=> (cmpBus.value[3][15:8] == $past(sfrWrData))
  ) else $error("compare high byte not stored");

  // an enabled comparator flags equality one cycle later
  a_match_pulse: assert property (
    @(posedge clk) disable iff (!rstn)
    (compareEnable[2] && count_reg == cmpBus.value[2]) |=> compareMatch[2]
  ) else $error("enabled comparator missed a match");

  // a disabled comparator never flags
  a_match_disabled: assert property (
    @(posedge clk) disable iff (!rstn)
    !compareEnable[0] |=> !compareMatch[0]
  ) else $error("disabled comparator flagged a match");

  // mode writes to module four are ignored under the watchdog
  a_wdog_mode_lock: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_MODE4 && watchdogEnable)
    |=> (compareEnable[4] == $past(compareEnable[4]))
  ) else $error("module four mode changed under watchdog");

  // counter low byte read returns the live low byte
  a_low_read_data: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrRdEn && sfrAddr == `CA_ADDR_COUNT_LOW)
    |=> (sfrRdValid && sfrRdHit && sfrRdData == $past(count_reg[7:0]))
  ) else $error("counter low byte read returned wrong data");

  // a tick without a write steps the count by one
  a_count_tick_step: assert property (
    @(posedge clk) disable iff (!rstn)
    (!sfrWrEn && countTick) |=> (count_reg == $past(count_reg) + 16'h0001)
  ) else $error("counter did not step on a tick");

  // no tick and no write keeps the count
  a_count_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    (!sfrWrEn && !countTick) |=> $stable(count_reg)
  ) else $error("counter moved without tick or write");

  // compare low byte of module zero reads back its stored byte
  a_cmp_low_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrRdEn && sfrAddr == `CA_ADDR_CMP0_LOW)
    |=> (sfrRdHit && sfrRdData == $past(cmpBus.value[0][7:0]))
  ) else $error("compare low byte read returned wrong data");

  // compare high byte of module four reads back its stored byte
  a_cmp_high_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrRdEn && sfrAddr == `CA_ADDR_CMP4_HIGH)
    |=> (sfrRdHit && sfrRdData == $past(cmpBus.value[4][15:8]))
  ) else $error("compare high byte read returned wrong data");

  // compare low write of module two clears its enable
  a_low_clears_two: assert property (
    @(posedge clk) disable iff (!rstn)
    (sfrWrEn && sfrAddr == `CA_ADDR_CMP2_LOW) |=> !compareEnable[2]
  ) else $error("module two enable not cleared by low write");

  // no equality means no match flag
  a_match_unequal: assert property (
    @(posedge clk) disable iff (!rstn)
    (count_reg != cmpBus.value[1]) |=> !compareMatch[1]
  ) else $error("comparator flagged without equality");

  // watchdog role output follows the enable bit one cycle late
  a_wdog_active_copy: assert property (
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> (watchdogActive == $past(watchdogEnable))
  ) else $error("watchdog role output does not follow enable");
endmodule : counter_array_regs

// *** tb/counter_array_regs_test.sv ***
// self-checking testbench of the counter array register front end
`timescale 1ns/10ps
module counter_array_regs_test;
  import counter_array_pkg::*;

  // design ports
  logic clk;
  logic rstn;
  byte_t sfrAddr;
  logic sfrWrEn;
  logic sfrRdEn;
  byte_t sfrWrData;
  byte_t sfrRdData;
  logic sfrRdValid;
  logic sfrRdHit;
  logic watchdogEnable;
  logic countTick;
  count_t countValue;
  logic [4:0] compareEnable;
  logic [4:0] compareMatch;
  logic watchdogActive;

  // bench state
  int nErrors;
  int totalChecks;
  logic [4:0] expEn;
  byte_t lowAddr [5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD};
  byte_t highAddr [5] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE};

  counter_array_regs #(
    .NUM_MODULES(5)
  ) dut (
    .clk(clk),
    .rstn(rstn),
    .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn),
    .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData),
    .sfrRdValid(sfrRdValid),
    .sfrRdHit(sfrRdHit),
    .watchdogEnable(watchdogEnable),
    .countTick(countTick),
    .countValue(countValue),
    .compareEnable(compareEnable),
    .compareMatch(compareMatch),
    .watchdogActive(watchdogActive)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  // verdict and end of run
  task automatic tally_and_finish();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // compare one value against its expectation
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one write strobe, entered and left at a falling edge
  task automatic reg_write(input byte_t a, input byte_t d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
    @(negedge clk);
  endtask : reg_write

  // one read strobe, waits a bounded time for the data pulse
  task automatic reg_read(input byte_t a, output byte_t d);
    int n;
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    n = 0;
    while (sfrRdValid !== 1'b1) begin
      n++;
      if (n > 4) begin
        nErrors++;
        tally_and_finish();
      end
      @(negedge clk);
    end
    d = sfrRdData;
    @(negedge clk);
  endtask : reg_read

  // read and compare in one call
  task automatic expect_read(input string what, input byte_t a, input byte_t exp);
    byte_t d;
    reg_read(a, d);
    check(what, {8'h00, d}, {8'h00, exp});
  endtask : expect_read

  // hang guard
  initial begin
    #400000;
    nErrors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    sfrWrData = 8'h00;
    watchdogEnable = 1'b0;
    countTick = 1'b0;
    nErrors = 0;
    totalChecks = 0;
    expEn = 5'h00;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    // reset values of the counter, the comparator enables and every compare byte
    check("countValue", countValue, 16'h0000);
    check("compareEnable", {11'h000, compareEnable}, 16'h0000);
    expect_read("count low", 8'hF9, 8'h00);
    expect_read("count high", 8'hFA, 8'h00);
    for (int i = 0; i < 5; i++) begin
      expect_read("cmp low reset", lowAddr[i], 8'h00);
      expect_read("cmp high reset", highAddr[i], 8'h00);
    end
    // compare bytes of every module and their enable side effects
    for (int i = 0; i < 5; i++) begin
      reg_write(highAddr[i], 8'hA0 + i[7:0]);
      expEn[i] = 1'b1;
      check("enable set", {11'h000, compareEnable}, {11'h000, expEn});
      reg_write(lowAddr[i], 8'h50 + i[7:0]);
      expEn[i] = 1'b0;
      check("enable clear", {11'h000, compareEnable}, {11'h000, expEn});
      reg_write(highAddr[i], 8'hC0 + i[7:0]);
      expEn[i] = 1'b1;
      check("enable set again", {11'h000, compareEnable}, {11'h000, expEn});
      expect_read("cmp low", lowAddr[i], 8'h50 + i[7:0]);
      expect_read("cmp high", highAddr[i], 8'hC0 + i[7:0]);
      check("read hit", {15'h0000, sfrRdHit}, 16'h0001);
    end
    // unmapped address answers zero without a hit
    expect_read("unmapped", 8'h00, 8'h00);
    check("unmapped hit", {15'h0000, sfrRdHit}, 16'h0000);
    // unlocked counter writes and the high byte snapshot
    reg_write(8'hF9, 8'h34);
    reg_write(8'hFA, 8'h12);
    check("count load", countValue, 16'h1234);
    expect_read("count low", 8'hF9, 8'h34);
    expect_read("snapshot", 8'hFA, 8'h12);
    reg_write(8'hFA, 8'h56);
    check("count high load", countValue, 16'h5634);
    expect_read("stale snapshot", 8'hFA, 8'h12);
    expect_read("count low again", 8'hF9, 8'h34);
    expect_read("fresh snapshot", 8'hFA, 8'h56);
    // match on module two, then disabled by a low byte write
    reg_write(8'hEB, 8'h34);
    reg_write(8'hEC, 8'h56);
    repeat (3) @(negedge clk);
    check("match", {11'h000, compareMatch}, 16'h0004);
    reg_write(8'hEB, 8'h34);
    repeat (3) @(negedge clk);
    check("match disabled", {11'h000, compareMatch}, 16'h0000);
    expEn[2] = 1'b0;
    check("enable after low", {11'h000, compareEnable}, {11'h000, expEn});
    // running counter advances once per tick
    countTick = 1'b1;
    repeat (10) @(negedge clk);
    countTick = 1'b0;
    @(negedge clk);
    check("count ticks", countValue, 16'h563E);
    // watchdog lock on counter bytes and module four mode
    watchdogEnable = 1'b1;
    @(negedge clk);
    check("watchdog active", {15'h0000, watchdogActive}, 16'h0001);
    reg_write(8'hF9, 8'hAA);
    check("locked low", countValue, 16'h563E);
    reg_write(8'hFA, 8'hBB);
    check("locked high", countValue, 16'h563E);
    reg_write(8'hDE, 8'h00);
    check("locked mode", {11'h000, compareEnable}, {11'h000, expEn});
    reg_write(8'hDA, 8'h00);
    expEn[0] = 1'b0;
    check("mode clear", {11'h000, compareEnable}, {11'h000, expEn});
    // writes take effect again once unlocked
    watchdogEnable = 1'b0;
    @(negedge clk);
    reg_write(8'hF9, 8'hAA);
    check("unlocked low", countValue, 16'h56AA);
    reg_write(8'hFA, 8'hBB);
    check("unlocked high", countValue, 16'hBBAA);
    tally_and_finish();
  end
endmodule : counter_array_regs_test
